// ===== pmcd_clock_divider.v
// Top of the phase matched clock divider with its Avalon-MM register slave
`timescale 1ns/10ps

module pmcd_clock_divider (
  clk,
  resetn,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  tx_chan_clk,
  rx_chan_clk,
  routing_clk,
  div_sel,
  div_rst,
  global_reset_hookup,
  same_rate_clock_out,
  divided_clock_out
);
  `include "pmcd_map.vh"

  input wire clk; // Register bus clock
  input wire resetn; // Asynchronous reset, active low
  input wire [3:0] avs_address; // Byte address
  input wire avs_read; // Read request
  input wire avs_write; // Write request
  input wire [31:0] avs_writedata; // Write data
  output reg [31:0] avs_readdata; // Read data, registered
  output wire avs_waitrequest; // Stall until the answer is ready
  input wire [3:0] tx_chan_clk; // Transmit channel clocks
  input wire [3:0] rx_chan_clk; // Receive channel clocks
  input wire routing_clk; // Clock from general routing
  input wire [2:0] div_sel; // Divide select from fabric logic
  input wire div_rst; // Divider reset, active high, asynchronous
  input wire global_reset_hookup; // Device wide reset, active high
  output wire same_rate_clock_out; // Undivided clock to primary routing
  output wire divided_clock_out; // Divided clock to primary routing

  // Bus side state
  reg [31:0] ctrl_q; // Source, global reset enable, override
  reg [31:0] scratch_q; // Free storage for software
  reg ack_q; // Answer cycle of a bus access
  reg [31:0] rdata_d; // Read mux result

  // Divider side state
  wire source_clock_in; // Selected input clock
  wire hold; // Forces both outputs low
  wire [2:0] eff_sel_w; // Select before synchronisation
  reg [2:0] sel_s1_q; // First stage, divider clock
  reg [2:0] sel_s2_q; // Second stage, divider clock

  // Status crossing back to the bus clock
  reg [2:0] stat_sel_s1_q;
  reg [2:0] stat_sel_s2_q;
  reg hold_s1_q;
  reg hold_s2_q;
  reg grst_s1_q;
  reg grst_s2_q;

  // Address decode shared by the read and write paths
  function [1:0] reg_index;
    input [3:0] addr;
    begin
      case (addr)
        `PMCD_OFS_CTRL: reg_index = 2'h1;
        `PMCD_OFS_STATUS: reg_index = 2'h2;
        `PMCD_OFS_SCRATCH: reg_index = 2'h3;
        default: reg_index = 2'h0;
      endcase
    end
  endfunction

  // One wait cycle on every access; the access completes in the ack cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Acknowledge alternates so back to back requests each see one stall
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // Register writes land on the edge where waitrequest is low
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `PMCD_CTRL_RESET;
      scratch_q <= `PMCD_SCRATCH_RESET;
    end else begin
      if (avs_write && ack_q) begin
        case (reg_index(avs_address))
          2'h1: ctrl_q <= avs_writedata & 32'h0000_0f1f;
          2'h3: scratch_q <= avs_writedata;
          default: begin
            // Status is read only; unmapped writes are dropped
          end
        endcase
      end
    end
  end

  // Read mux; reserved bits read as zero
  always @* begin
    rdata_d = 32'h0000_0000;
    case (reg_index(avs_address))
      2'h1: rdata_d = ctrl_q;
      2'h2: begin
        rdata_d[`PMCD_STAT_SEL_MSB:`PMCD_STAT_SEL_LSB] = stat_sel_s2_q;
        rdata_d[`PMCD_STAT_HOLD_BIT] = hold_s2_q;
        rdata_d[`PMCD_STAT_OVR_BIT] = ctrl_q[`PMCD_CTRL_OVR_EN_BIT];
      end
      2'h3: rdata_d = scratch_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data is captured on the edge that raises the acknowledge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdata_d;
    end
  end

  // Input clock chosen from channel or routing clocks
  pmcd_src_mux u_src_mux (
    .tx_chan_clk(tx_chan_clk),
    .rx_chan_clk(rx_chan_clk),
    .routing_clk(routing_clk),
    .src_sel(ctrl_q[`PMCD_CTRL_SRC_MSB:`PMCD_CTRL_SRC_LSB]),
    .source_clock_in(source_clock_in)
  );

  // Global reset only reaches the divider when software enables it
  assign hold = ~resetn | div_rst |
    (global_reset_hookup & ctrl_q[`PMCD_CTRL_GRST_EN_BIT]);

  // Software override of the select, otherwise the fabric select
  assign eff_sel_w = ctrl_q[`PMCD_CTRL_OVR_EN_BIT] ?
    ctrl_q[`PMCD_CTRL_OVR_MSB:`PMCD_CTRL_OVR_LSB] : div_sel;

  // Select passes two flops on the divider clock; bits may land one edge
  // apart, acceptable since a ratio change is not glitch free anyway
  always @(posedge source_clock_in or posedge hold) begin
    if (hold) begin
      sel_s1_q <= `PMCD_SEL_OFF0;
      sel_s2_q <= `PMCD_SEL_OFF0;
    end else begin
      sel_s1_q <= eff_sel_w;
      sel_s2_q <= sel_s1_q;
    end
  end

  // Counter and matched output stage
  pmcd_div_core u_div_core (
    .source_clock_in(source_clock_in),
    .hold(hold),
    .div_sel(sel_s2_q),
    .same_rate_clock_out(same_rate_clock_out),
    .divided_clock_out(divided_clock_out)
  );

  // Status back to the bus clock; select through two flops, hold through four
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_sel_s1_q <= `PMCD_SEL_OFF0;
      stat_sel_s2_q <= `PMCD_SEL_OFF0;
      hold_s1_q <= 1'b1;
      hold_s2_q <= 1'b1;
      grst_s1_q <= 1'b0;
      grst_s2_q <= 1'b0;
    end else begin
      stat_sel_s1_q <= eff_sel_w;
      stat_sel_s2_q <= stat_sel_s1_q;
      grst_s1_q <= div_rst | (global_reset_hookup & ctrl_q[`PMCD_CTRL_GRST_EN_BIT]);
      grst_s2_q <= grst_s1_q;
      hold_s1_q <= grst_s2_q;
      hold_s2_q <= hold_s1_q;
    end
  end

endmodule // pmcd_clock_divider

// ===== pmcd_map.vh
// Constants for the phase matched clock divider: offsets, fields, resets, codes
//
// Overview of operation
// - Divide select picks 1,2,4,5,8,10; 000/111 low
// - Reset high forces both clock outputs low
// - Same rate output follows input clock exactly
// - Both outputs keep matched delay and phase
// - New divide select applied on the fly
// - Input from tx, rx or routing clock
// - Both outputs drive primary clock routing directly
// - Global reset hookup optional, disconnected by default
`ifndef PMCD_MAP_VH
`define PMCD_MAP_VH

// Register byte offsets
`define PMCD_OFS_CTRL 4'h0
`define PMCD_OFS_STATUS 4'h4
`define PMCD_OFS_SCRATCH 4'h8

// Control register fields
`define PMCD_CTRL_SRC_LSB 0
`define PMCD_CTRL_SRC_MSB 3
`define PMCD_CTRL_GRST_EN_BIT 4
`define PMCD_CTRL_OVR_EN_BIT 8
`define PMCD_CTRL_OVR_LSB 9
`define PMCD_CTRL_OVR_MSB 11

// Status register fields
`define PMCD_STAT_SEL_LSB 0
`define PMCD_STAT_SEL_MSB 2
`define PMCD_STAT_HOLD_BIT 3
`define PMCD_STAT_OVR_BIT 4

// Reset values
`define PMCD_CTRL_RESET 32'h0000_0000
`define PMCD_SCRATCH_RESET 32'h0000_0000

// Source select codes
`define PMCD_SRC_TX0 4'h0
`define PMCD_SRC_RX0 4'h4
`define PMCD_SRC_ROUTING 4'h8

// Divide select codes
`define PMCD_SEL_OFF0 3'h0
`define PMCD_SEL_DIV1 3'h1
`define PMCD_SEL_DIV2 3'h2
`define PMCD_SEL_DIV4 3'h3
`define PMCD_SEL_DIV5 3'h4
`define PMCD_SEL_DIV8 3'h5
`define PMCD_SEL_DIV10 3'h6
`define PMCD_SEL_OFF7 3'h7

// Counter idle marker held in reset; forces wrap to zero on first edge
`define PMCD_CNT_IDLE 4'hf

`endif

// ===== pmcd_src_mux.v
// Input clock source selector for the divider
`timescale 1ns/10ps

module pmcd_src_mux (
  tx_chan_clk,
  rx_chan_clk,
  routing_clk,
  src_sel,
  source_clock_in
);
  `include "pmcd_map.vh"

  input wire [3:0] tx_chan_clk; // Transmit channel clocks
  input wire [3:0] rx_chan_clk; // Receive channel clocks
  input wire routing_clk; // Clock from general routing
  input wire [3:0] src_sel; // Static source choice
  output wire source_clock_in; // Selected divider input clock

  // Channel clocks enter here directly, never through a primary clock
  function pick_clock;
    input [3:0] sel;
    input [3:0] tx;
    input [3:0] rx;
    input rt;
    begin
      if (sel < `PMCD_SRC_RX0) begin
        pick_clock = tx[sel[1:0]];
      end else if (sel < `PMCD_SRC_ROUTING) begin
        pick_clock = rx[sel[1:0]];
      end else if (sel == `PMCD_SRC_ROUTING) begin
        pick_clock = rt;
      end else begin
        // Unused codes park the input low
        pick_clock = 1'b0;
      end
    end
  endfunction

  // Plain mux; changing the source while running is not glitch free
  assign source_clock_in = pick_clock(src_sel, tx_chan_clk, rx_chan_clk, routing_clk);

endmodule // pmcd_src_mux

// ===== pmcd_div_core.v
// Divide counter and matched clock output stage, on the selected input clock
`timescale 1ns/10ps

module pmcd_div_core (
  source_clock_in,
  hold,
  div_sel,
  same_rate_clock_out,
  divided_clock_out
);
  `include "pmcd_map.vh"

  input wire source_clock_in; // Divider input clock
  input wire hold; // Asynchronous hold, active high
  input wire [2:0] div_sel; // Divide select, already on this clock
  output wire same_rate_clock_out; // Undivided copy
  output wire divided_clock_out; // Divided copy

  reg [3:0] cnt_q; // Position within the divided period
  reg [3:0] cnt_d;
  reg phase_q; // Divided level for ratios above one
  reg phase_d;
  reg [3:0] last_w; // Final count of the period
  reg [3:0] high_w; // Cycles spent high

  // Ratio table: last count and high time per select code
  always @* begin
    last_w = 4'h0;
    high_w = 4'h0;
    case (div_sel)
      `PMCD_SEL_DIV2: begin
        last_w = 4'h1;
        high_w = 4'h1;
      end
      `PMCD_SEL_DIV4: begin
        last_w = 4'h3;
        high_w = 4'h2;
      end
      `PMCD_SEL_DIV5: begin
        // Odd ratio: two high, three low
        last_w = 4'h4;
        high_w = 4'h2;
      end
      `PMCD_SEL_DIV8: begin
        last_w = 4'h7;
        high_w = 4'h4;
      end
      `PMCD_SEL_DIV10: begin
        last_w = 4'h9;
        high_w = 4'h5;
      end
      default: begin
        // Divide by one and the off codes use no counter
        last_w = 4'h0;
        high_w = 4'h0;
      end
    endcase
  end

  // Next count; a count past a new shorter ratio simply wraps
  always @* begin
    if (high_w == 4'h0) begin
      cnt_d = `PMCD_CNT_IDLE;
      phase_d = 1'b0;
    end else begin
      if (cnt_q >= last_w) begin
        cnt_d = 4'h0;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
      phase_d = (cnt_d < high_w);
    end
  end

  // Idle marker in reset makes the first edge after release start a period
  always @(posedge source_clock_in or posedge hold) begin
    if (hold) begin
      cnt_q <= `PMCD_CNT_IDLE;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
    end
  end

  // Both outputs gated by the same hold term so their delay stays matched
  assign same_rate_clock_out = source_clock_in & ~hold;
  assign divided_clock_out = (div_sel == `PMCD_SEL_DIV1) ? (source_clock_in & ~hold) :
    (phase_q & ~hold);

endmodule // pmcd_div_core

// ===== pmcd_clock_divider_properties.sv
// Port checker for the phase matched clock divider
`timescale 1ns/10ps
module pmcd_checker (
  input wire clk,
  input wire resetn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [3:0] tx_chan_clk,
  input wire [2:0] div_sel,
  input wire div_rst,
  input wire global_reset_hookup,
  input wire same_rate_clock_out,
  input wire divided_clock_out
);
  // Any hold source; hookup counts as hold because the enable bit is not visible here
  wire hold_any = !resetn || div_rst || global_reset_hookup;
  reset_forces_low_a: assert property (@(posedge clk)
    (!resetn || div_rst) |-> !same_rate_clock_out && !divided_clock_out)
    else $error("clock outputs not low in reset");
  rate_high_a: assert property (@(negedge tx_chan_clk[0]) disable iff (hold_any) same_rate_clock_out)
    else $error("same rate output missed a high phase");
  rate_low_a: assert property (@(posedge tx_chan_clk[0]) disable iff (hold_any) !same_rate_clock_out)
    else $error("same rate output missed a low phase");
  edge_match_a: assert property (@(negedge tx_chan_clk[0]) disable iff (hold_any)
    $rose(divided_clock_out) |-> same_rate_clock_out)
    else $error("divided edge not aligned");
  div_two_a: assert property (@(posedge tx_chan_clk[0]) disable iff (hold_any || div_sel != 3'h2)
    $rose(divided_clock_out) && $past(div_sel, 4) == 3'h2 |=> !divided_clock_out ##1 divided_clock_out)
    else $error("divide by two period wrong");
  div_five_a: assert property (@(posedge tx_chan_clk[0]) disable iff (hold_any || div_sel != 3'h4)
    $rose(divided_clock_out) && $past(div_sel, 4) == 3'h4
    |=> divided_clock_out ##1 !divided_clock_out [*3] ##1 divided_clock_out)
    else $error("divide by five shape wrong");
  // The select synchroniser restarts from the off code after a hold, so wait three edges past release
  div_one_a: assert property (@(negedge tx_chan_clk[0]) disable iff (hold_any || div_sel != 3'h1)
    $past(div_sel, 4) == 3'h1 && !$past(hold_any, 1) && !$past(hold_any, 2) && !$past(hold_any, 3)
    |-> divided_clock_out)
    else $error("divide by one output not following");
  off_low_a: assert property (@(posedge tx_chan_clk[0]) disable iff (hold_any)
    (div_sel == 3'h0 || div_sel == 3'h7) && $past(div_sel, 4) == div_sel |-> !divided_clock_out)
    else $error("divided output not low for off code");
  bus_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
endmodule // pmcd_checker

bind pmcd_clock_divider pmcd_checker pmcd_checker_inst (.clk, .resetn, .avs_read, .avs_write, .avs_waitrequest,
  .tx_chan_clk, .div_sel, .div_rst, .global_reset_hookup, .same_rate_clock_out, .divided_clock_out);

// ===== pmcd_fabric_model.sv
// Fabric width converter model clocked from both divider outputs
`timescale 1ns/10ps
module pmcd_fabric_model (
  input wire same_rate_clock_out,
  input wire divided_clock_out,
  output reg [7:0] ratio_seen,
  output reg [15:0] rise_count
);
  reg [15:0] fast_q; // Fast domain edge count
  reg [15:0] mark_q; // Fast count at last slow edge
  initial begin
    fast_q = 16'h0;
    mark_q = 16'h0;
    ratio_seen = 8'h0;
    rise_count = 16'h0;
  end
  // Wide side counts fast edges
  always @(posedge same_rate_clock_out) begin
    fast_q <= fast_q + 16'h1;
  end
  // Narrow side takes the count directly; the first period after a ratio change may be a runt, so readers wait
  always @(posedge divided_clock_out) begin
    ratio_seen <= fast_q[7:0] - mark_q[7:0];
    mark_q <= fast_q;
    rise_count <= rise_count + 16'h1;
  end
endmodule // pmcd_fabric_model

// ===== pmcd_clock_divider_tb.sv
// Self checking bench for the phase matched clock divider
`timescale 1ns/10ps
module pmcd_clock_divider_tb;
  reg clk = 1'b0; // Bus clock
  reg resetn = 1'b0; // Bus reset, active low
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  reg [3:0] tx_chan_clk = 4'h0; // Selected source after reset
  reg [3:0] rx_chan_clk = 4'h0;
  reg routing_clk = 1'b0;
  reg [2:0] div_sel = 3'h1;
  reg div_rst = 1'b0;
  reg global_reset_hookup = 1'b0;
  wire same_rate_clock_out;
  wire divided_clock_out;
  wire [7:0] ratio_seen;
  wire [15:0] rise_count;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer seed = 17062;
  integer i;
  integer k;
  reg [31:0] rd;
  reg [31:0] wd;
  reg [2:0] code;
  reg [15:0] r0;
  always #5 clk = ~clk;
  // Source clocks are unrelated to the bus clock
  always #6 tx_chan_clk = ~tx_chan_clk;
  always #7 rx_chan_clk = ~rx_chan_clk;
  always #9 routing_clk = ~routing_clk;
  pmcd_clock_divider pmcd_clock_divider_inst (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tx_chan_clk, .rx_chan_clk, .routing_clk, .div_sel, .div_rst,
    .global_reset_hookup, .same_rate_clock_out, .divided_clock_out);
  pmcd_fabric_model pmcd_fabric_model_inst (.same_rate_clock_out, .divided_clock_out, .ratio_seen, .rise_count);
  // Ratio in fast edges per slow edge; zero means held low
  function [7:0] exp_ratio(input [2:0] c);
    case (c)
      3'h1: exp_ratio = 8'h1;
      3'h2: exp_ratio = 8'h2;
      3'h3: exp_ratio = 8'h4;
      3'h4: exp_ratio = 8'h5;
      3'h5: exp_ratio = 8'h8;
      3'h6: exp_ratio = 8'ha;
      default: exp_ratio = 8'h0;
    endcase
  endfunction
  task check_val(input string what, input [31:0] exp, input [31:0] seen);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle held until waitrequest is sampled low
  task bus_op(input wr, input [3:0] a, input [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wait_src(input integer n);
    repeat (n) @(posedge tx_chan_clk[0]);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog, well beyond the expected run of about 10 us
  initial begin
    #300000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus_op(1'b0, 4'h0, 32'h0);
    check_val("ctrl reset", 32'h0, rd);
    bus_op(1'b0, 4'hc, 32'h0);
    check_val("unmapped read", 32'h0, rd);
    wd = $random(seed);
    bus_op(1'b1, 4'h8, wd);
    bus_op(1'b0, 4'h8, 32'h0);
    check_val("scratch", wd, rd);
    bus_op(1'b1, 4'h4, 32'h1f);
    bus_op(1'b0, 4'h4, 32'h0);
    check_val("status select", 32'h1, rd & 32'h1f);
    // Every code, then random ones, switched on the fly without reset
    for (i = 0; i < 14; i = i + 1) begin
      wd = $random(seed);
      code = (i < 8) ? i[2:0] : wd[2:0];
      @(posedge clk) div_sel <= code;
      wait_src(30);
      r0 = rise_count;
      wait_src(24);
      if (exp_ratio(code) == 8'h0) check_val("rises while off", {16'h0, r0}, {16'h0, rise_count});
      else check_val("ratio", {24'h0, exp_ratio(code)}, {24'h0, ratio_seen});
    end
    // Software override takes the place of the fabric select; reserved bits in the write are dropped
    @(posedge clk) div_sel <= 3'h3;
    bus_op(1'b1, 4'h0, 32'hfff0_f5e0);
    wait_src(30);
    check_val("override ratio", 32'h2, {24'h0, ratio_seen});
    bus_op(1'b0, 4'h0, 32'h0);
    check_val("ctrl mask", 32'h500, rd);
    bus_op(1'b0, 4'h4, 32'h0);
    check_val("status override", 32'h12, rd & 32'h1f);
    bus_op(1'b1, 4'h0, 32'h0);
    // Hold, then count source edges to the first divided edge
    @(posedge clk) div_sel <= 3'h3;
    div_rst <= 1'b1;
    wait_src(4);
    check_val("held low", 32'h0, {30'h0, same_rate_clock_out, divided_clock_out});
    bus_op(1'b0, 4'h4, 32'h0);
    check_val("status hold", 32'h8, rd & 32'h8);
    @(posedge clk) div_rst <= 1'b0;
    k = 0;
    while (divided_clock_out !== 1'b1 && k < 20) begin
      @(posedge tx_chan_clk[0]);
      #1;
      k = k + 1;
    end
    check_val("first divided edge", 32'h3, k);
    check_val("edges together", 32'h1, {31'h0, same_rate_clock_out});
    // Hookup ignored until enabled
    @(posedge clk) global_reset_hookup <= 1'b1;
    r0 = rise_count;
    wait_src(20);
    check_val("hookup disconnected", 32'h1, {31'h0, rise_count != r0});
    bus_op(1'b1, 4'h0, 32'h10);
    wait_src(2);
    check_val("hookup enabled", 32'h0, {30'h0, same_rate_clock_out, divided_clock_out});
    print_verdict;
  end
endmodule // pmcd_clock_divider_tb
